//--- common/spi_evt_consts.svh
/*
 Register offsets, field positions, reset values and counts of the serial
 status, event and clock auto-stop block.
 Assumes it is included by bare name wherever these numbers are needed.
*/
`ifndef SPI_EVT_CONSTS_SVH
`define SPI_EVT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------------
`define OFS_STATUS    8'h00
`define OFS_CTRL2     8'h04
`define OFS_IRQ_STAT  8'h08
`define OFS_IRQ_CLR   8'h0C
`define OFS_IRQ_EN    8'h10

// ----------------------------------------------------------------------------
// Field positions of the serial status register.
// ----------------------------------------------------------------------------
`define ST_TXE   0
`define ST_RXF   1
`define ST_MODE_FAULT_FLAG  2
`define ST_UDR   3
`define ST_OVR   4
`define ST_PAR   5
`define ST_WIDTH 6

// ----------------------------------------------------------------------------
// Field positions and reset value of control register two.
// ----------------------------------------------------------------------------
`define C2_AUTOSTOP 0
`define C2_MASTER   1
`define C2_MSTOP    2
`define C2_WIDTH    3
`define C2_RESET    3'h4

// ----------------------------------------------------------------------------
// Event bit positions, shared by event outputs and interrupt registers.
// ----------------------------------------------------------------------------
`define EV_RXF   0
`define EV_TXE   1
`define EV_ERR   2
`define EV_IDLE  3
`define EV_TEND  4
`define EV_COUNT 5

// ----------------------------------------------------------------------------
// Frame length and bus answers.
// ----------------------------------------------------------------------------
`define WORD_BITS   8
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

//--- common/spi_evt_pkg.sv
/*
 Types of the serial status, event and clock auto-stop block.
 Assumes nothing of its surroundings.
*/
package spi_evt_pkg;

	// ------------------------------------------------------------------------
	// Link tracker states.
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {LINK_IDLE, LINK_ACTIVE, LINK_HALTED} link_state_t;

endpackage

//--- core/edge_sampler.sv
/*
 Three-stage sampler for a pin from outside the clock domain, with a
 debounced level and one-cycle rise and fall pulses.
 Assumes the pin changes slower than a few system clock periods.
*/
`timescale 1ns/1ps

module edge_sampler (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	logic s1;
	logic s2;
	logic s3;
	logic next_level;
	logic next_rise;
	logic next_fall;

	// ------------------------------------------------------------------------
	// A change counts only once the second and third stage agree; the first
	// stage may be metastable, so only the second stage reads it.
	// ------------------------------------------------------------------------
	always_comb
	begin
		next_level = level_o;
		next_rise  = 1'b0;
		next_fall  = 1'b0;
		if (s2 == s3 && s3 != level_o)
		begin
			next_level = s3;
			next_rise  = s3;
			next_fall  = !s3;
		end
	end

	// Registers of the sampler.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1      <= 1'b0;
			s2      <= 1'b0;
			s3      <= 1'b0;
			level_o <= 1'b0;
			rise_o  <= 1'b0;
			fall_o  <= 1'b0;
		end
		else
		begin
			s1      <= pin_i;
			s2      <= s1;
			s3      <= s2;
			level_o <= next_level;
			rise_o  <= next_rise;
			fall_o  <= next_fall;
		end
	end

endmodule

//--- core/irq_block.sv
/*
 Sticky interrupt status with a write-only clear and an enable register,
 one bit per event, combined into one level interrupt.
 Assumes event pulses and register strobes come from the same clock.
*/
`timescale 1ns/1ps

module irq_block #(
	parameter int N = 5
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic [N-1:0] event_i,
	input  wire logic         clear_we_i,
	input  wire logic [N-1:0] clear_data_i,
	input  wire logic         enable_we_i,
	input  wire logic [N-1:0] enable_data_i,
	output logic      [N-1:0] status_o,
	output logic      [N-1:0] enable_o,
	output logic              irq_o
);

	// ------------------------------------------------------------------------
	// Per-bit status and enable; an event in the clearing cycle survives.
	// ------------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_bit
			logic next_status;
			logic next_enable;

			// Set wins over clear so that no event is lost.
			always_comb
			begin
				next_status = event_i[i] | (status_o[i] & ~(clear_we_i & clear_data_i[i]));
				next_enable = enable_we_i ? enable_data_i[i] : enable_o[i];
			end

			// Status and enable registers.
			always_ff @(posedge clk_sys_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					status_o[i] <= 1'b0;
					enable_o[i] <= 1'b0;
				end
				else
				begin
					status_o[i] <= next_status;
					enable_o[i] <= next_enable;
				end
			end
		end
	endgenerate

	// The interrupt is a level, high while an enabled status bit is set.
	assign irq_o = |(status_o & enable_o);

endmodule

//--- core/spi_status_event.sv
/*
 Status flags, event-link outputs, error events and transfer clock
 auto-stop of a serial peripheral unit, with an AXI4-Lite register slave.
 Assumes a data path beside it reports buffer reads, writes and parity
 errors on this clock, and a master sequencer obeys clock_halt_o.
*/
// What this block does
// - Only unit zero drives the event-link outputs, pulsing buffer-full and buffer-empty events.
// - Any mode fault, overrun, underrun or parity error raises one combined error event.
// - An idle event is given when the unit goes idle and a separate one when a transfer ends.
// - Software reads transmit-buffer-empty and receive-buffer-full flags in the status register.
// - Control register two holds the clock auto-stop enable bit.
// - In master receive with auto-stop on, the clock halts where an overrun would occur.
// - The mode-fault flag reads 1 after a mode fault or an underrun and 0 otherwise.
// - The status register has its own underrun flag besides the shared mode-fault flag.
// - A module stop state halts the serial unit until it is released.
`timescale 1ns/1ps
`include "spi_evt_consts.svh"

module spi_status_event #(
	parameter int UNIT_INDEX = 0
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  awaddr_i,
	input  wire logic        awvalid_i,
	output logic             awready_o,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	input  wire logic        wvalid_i,
	output logic             wready_o,
	output logic [1:0]       bresp_o,
	output logic             bvalid_o,
	input  wire logic        bready_i,
	input  wire logic [7:0]  araddr_i,
	input  wire logic        arvalid_i,
	output logic             arready_o,
	output logic [31:0]      rdata_o,
	output logic [1:0]       rresp_o,
	output logic             rvalid_o,
	input  wire logic        rready_i,
	input  wire logic        serial_transfer_clock_i,
	input  wire logic        fault_select_n_i,
	input  wire logic        rx_buffer_read_i,
	input  wire logic        tx_buffer_write_i,
	input  wire logic        parity_error_i,
	output logic             clock_halt_o,
	output logic             evt_rx_full_o,
	output logic             evt_tx_empty_o,
	output logic             evt_error_o,
	output logic             evt_idle_o,
	output logic             evt_tx_done_o,
	output logic             irq_o
);

	localparam logic [3:0] LAST_BIT = 4'(`WORD_BITS - 1);
	localparam logic       UNIT_ON  = (UNIT_INDEX == 0);

	// ------------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------------
	spi_evt_pkg::link_state_t link_state;
	spi_evt_pkg::link_state_t next_link_state;
	logic [3:0]           bit_cnt;
	logic [3:0]           next_bit_cnt;
	logic [`C2_WIDTH-1:0] ctrl2;
	logic [`C2_WIDTH-1:0] next_ctrl2;
	logic tx_empty, rx_full, mf_err, udr_err, ovr_err, par_err;
	logic next_tx_empty, next_rx_full, next_mf, next_udr, next_ovr, next_par;
	logic det_mf, det_udr, det_ovr, det_par, det_any;
	logic frame_start, frame_done, at_last;
	logic sck_rise, fault_fall;
	logic autostop, master, mstop;
	logic [`ST_WIDTH-1:0]  status_word;
	logic [`EV_COUNT-1:0]  ev_now;
	logic [`EV_COUNT-1:0]  next_ev;
	logic [`EV_COUNT-1:0]  ev_q;
	logic [`EV_COUNT-1:0]  irq_status;
	logic [`EV_COUNT-1:0]  irq_enable;
	logic        aw_hold, w_hold, next_aw_hold, next_w_hold;
	logic [7:0]  aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic        w_low, next_w_low;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        wr_fire, wr_stat, wr_ctrl, wr_clr, wr_en, wr_ok;

	assign autostop = ctrl2[`C2_AUTOSTOP];
	assign master   = ctrl2[`C2_MASTER];
	assign mstop    = ctrl2[`C2_MSTOP];

	// ------------------------------------------------------------------------
	// Pin sampling: transfer clock edges and the active-low fault select.
	// ------------------------------------------------------------------------
	edge_sampler u_sck (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.pin_i     (serial_transfer_clock_i),
		.level_o   (),
		.rise_o    (sck_rise),
		.fall_o    ()
	);

	edge_sampler u_fault (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.pin_i     (fault_select_n_i),
		.level_o   (),
		.rise_o    (),
		.fall_o    (fault_fall)
	);

	// ------------------------------------------------------------------------
	// Link tracker: counts clock edges per frame and, in master mode with auto-stop on,
	// holds a halted frame until the receive buffer drains, so received data are not lost.
	// ------------------------------------------------------------------------
	assign frame_start = link_state == spi_evt_pkg::LINK_IDLE && sck_rise && !mstop;
	assign at_last     = link_state == spi_evt_pkg::LINK_ACTIVE && sck_rise
		&& bit_cnt == LAST_BIT && !mstop;

	always_comb
	begin
		next_link_state = link_state;
		next_bit_cnt    = bit_cnt;
		frame_done      = 1'b0;
		det_ovr         = 1'b0;
		if (mstop)
		begin
			next_link_state = spi_evt_pkg::LINK_IDLE;
			next_bit_cnt    = 4'h0;
		end
		else
		begin
			unique case (link_state)
				spi_evt_pkg::LINK_IDLE:
				begin
					if (frame_start)
					begin
						next_link_state = spi_evt_pkg::LINK_ACTIVE;
						next_bit_cnt    = 4'h1;
					end
				end
				spi_evt_pkg::LINK_ACTIVE:
				begin
					if (at_last && rx_full && master && autostop)
						next_link_state = spi_evt_pkg::LINK_HALTED;
					else if (at_last)
					begin
						frame_done      = 1'b1;
						det_ovr         = rx_full;
						next_link_state = spi_evt_pkg::LINK_IDLE;
						next_bit_cnt    = 4'h0;
					end
					else if (sck_rise)
						next_bit_cnt = bit_cnt + 4'h1;
				end
				spi_evt_pkg::LINK_HALTED:
				begin
					if (rx_buffer_read_i)
					begin
						frame_done      = 1'b1;
						next_link_state = spi_evt_pkg::LINK_IDLE;
						next_bit_cnt    = 4'h0;
					end
				end
			endcase
		end
	end

	// Link tracker registers.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			link_state <= spi_evt_pkg::LINK_IDLE;
			bit_cnt    <= 4'h0;
		end
		else
		begin
			link_state <= next_link_state;
			bit_cnt    <= next_bit_cnt;
		end
	end

	// The master sequencer stops the clock while halted or stopped.
	assign clock_halt_o = mstop || link_state == spi_evt_pkg::LINK_HALTED;

	// ------------------------------------------------------------------------
	// Buffer and error flags. Hardware sets win over software clears.
	// ------------------------------------------------------------------------
	assign det_udr = frame_start && !master && tx_empty;
	assign det_mf  = master && fault_fall && !mstop;
	assign det_par = parity_error_i && !mstop;
	assign det_any = det_mf | det_udr | det_ovr | det_par;

	always_comb
	begin
		next_tx_empty = frame_start | (tx_empty & ~tx_buffer_write_i);
		next_rx_full  = frame_done | (rx_full & ~rx_buffer_read_i);
		next_mf  = det_mf  | (mf_err  & ~(wr_stat & w_low & ~w_data[`ST_MODE_FAULT_FLAG]));
		next_udr = det_udr | (udr_err & ~(wr_stat & w_low & ~w_data[`ST_UDR]));
		next_ovr = det_ovr | (ovr_err & ~(wr_stat & w_low & ~w_data[`ST_OVR]));
		next_par = det_par | (par_err & ~(wr_stat & w_low & ~w_data[`ST_PAR]));
	end

	// Flag registers.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_empty <= 1'b1;
			rx_full  <= 1'b0;
			mf_err   <= 1'b0;
			udr_err  <= 1'b0;
			ovr_err  <= 1'b0;
			par_err  <= 1'b0;
		end
		else
		begin
			tx_empty <= next_tx_empty;
			rx_full  <= next_rx_full;
			mf_err   <= next_mf;
			udr_err  <= next_udr;
			ovr_err  <= next_ovr;
			par_err  <= next_par;
		end
	end

	// Underrun also shows on the mode-fault flag, as old software expects.
	always_comb
	begin
		status_word           = '0;
		status_word[`ST_TXE]  = tx_empty;
		status_word[`ST_RXF]  = rx_full;
		status_word[`ST_MODE_FAULT_FLAG] = mf_err | udr_err;
		status_word[`ST_UDR]  = udr_err;
		status_word[`ST_OVR]  = ovr_err;
		status_word[`ST_PAR]  = par_err;
	end

	// ------------------------------------------------------------------------
	// Event pulses; only unit zero drives them to the event-link outputs.
	// ------------------------------------------------------------------------
	always_comb
	begin
		ev_now           = '0;
		ev_now[`EV_RXF]  = next_rx_full & ~rx_full;
		ev_now[`EV_TXE]  = next_tx_empty & ~tx_empty;
		ev_now[`EV_ERR]  = det_any;
		ev_now[`EV_IDLE] = frame_done & tx_empty;
		ev_now[`EV_TEND] = frame_done;
		next_ev          = UNIT_ON ? ev_now : '0;
	end

	// Event output registers.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
			ev_q <= '0;
		else
			ev_q <= next_ev;
	end

	assign evt_rx_full_o  = ev_q[`EV_RXF];
	assign evt_tx_empty_o = ev_q[`EV_TXE];
	assign evt_error_o    = ev_q[`EV_ERR];
	assign evt_idle_o     = ev_q[`EV_IDLE];
	assign evt_tx_done_o  = ev_q[`EV_TEND];

	irq_block #(
		.N (`EV_COUNT)
	) u_irq (
		.clk_sys_i     (clk_sys_i),
		.rst_i         (rst_i),
		.event_i       (ev_now),
		.clear_we_i    (wr_clr),
		.clear_data_i  (w_data[`EV_COUNT-1:0]),
		.enable_we_i   (wr_en),
		.enable_data_i (w_data[`EV_COUNT-1:0]),
		.status_o      (irq_status),
		.enable_o      (irq_enable),
		.irq_o         (irq_o)
	);

	// ------------------------------------------------------------------------
	// AXI4-Lite slave. Address and data are held until both are in; every
	// field lives in byte lane zero, so only that lane's strobe matters.
	// ------------------------------------------------------------------------
	assign awready_o = !aw_hold && !bvalid_o;
	assign wready_o  = !w_hold && !bvalid_o;
	assign arready_o = !rvalid_o;
	assign wr_fire   = aw_hold && w_hold;

	always_comb
	begin
		wr_stat = wr_fire && aw_addr == `OFS_STATUS;
		wr_ctrl = wr_fire && aw_addr == `OFS_CTRL2;
		wr_clr  = wr_fire && aw_addr == `OFS_IRQ_CLR && w_low;
		wr_en   = wr_fire && aw_addr == `OFS_IRQ_EN && w_low;
		wr_ok   = wr_stat || wr_ctrl || aw_addr == `OFS_IRQ_CLR || aw_addr == `OFS_IRQ_EN;
		next_aw_hold = wr_fire ? 1'b0 : (aw_hold | (awvalid_i & awready_o));
		next_w_hold  = wr_fire ? 1'b0 : (w_hold | (wvalid_i & wready_o));
		next_aw_addr = (awvalid_i && awready_o) ? awaddr_i : aw_addr;
		next_w_data  = (wvalid_i && wready_o) ? wdata_i : w_data;
		next_w_low   = (wvalid_i && wready_o) ? wstrb_i[0] : w_low;
		next_ctrl2   = (wr_ctrl && w_low) ? w_data[`C2_WIDTH-1:0] : ctrl2;
		next_bvalid  = wr_fire | (bvalid_o & ~bready_i);
		next_bresp   = wr_fire ? (wr_ok ? `RESP_OKAY : `RESP_SLVERR) : bresp_o;
		next_rvalid  = (arvalid_i & arready_o) | (rvalid_o & ~rready_i);
		next_rdata   = rdata_o;
		next_rresp   = rresp_o;
		if (arvalid_i && arready_o)
		begin
			next_rresp = `RESP_OKAY;
			unique case (araddr_i)
				`OFS_STATUS:   next_rdata = 32'(status_word);
				`OFS_CTRL2:    next_rdata = 32'(ctrl2);
				`OFS_IRQ_STAT: next_rdata = 32'(irq_status);
				`OFS_IRQ_CLR:  next_rdata = 32'h00000000;
				`OFS_IRQ_EN:   next_rdata = 32'(irq_enable);
				default:
				begin
					next_rdata = 32'h00000000;
					next_rresp = `RESP_SLVERR;
				end
			endcase
		end
	end

	// Bus and control registers; module stop is set out of reset.
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_hold  <= 1'b0;
			w_hold   <= 1'b0;
			aw_addr  <= 8'h00;
			w_data   <= 32'h00000000;
			w_low    <= 1'b0;
			ctrl2    <= `C2_RESET;
			bvalid_o <= 1'b0;
			bresp_o  <= `RESP_OKAY;
			rvalid_o <= 1'b0;
			rdata_o  <= 32'h00000000;
			rresp_o  <= `RESP_OKAY;
		end
		else
		begin
			aw_hold  <= next_aw_hold;
			w_hold   <= next_w_hold;
			aw_addr  <= next_aw_addr;
			w_data   <= next_w_data;
			w_low    <= next_w_low;
			ctrl2    <= next_ctrl2;
			bvalid_o <= next_bvalid;
			bresp_o  <= next_bresp;
			rvalid_o <= next_rvalid;
			rdata_o  <= next_rdata;
			rresp_o  <= next_rresp;
		end
	end

	// ------------------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	unit_gate_a: assert property (!UNIT_ON |-> ev_q == '0)
		else $error("Event output from a unit other than zero.");

	rx_event_a: assert property (UNIT_ON && $rose(rx_full) |-> evt_rx_full_o)
		else $error("Receive buffer full event missing.");

	error_event_a: assert property (UNIT_ON && det_any |=> evt_error_o ##1 (!evt_error_o || $past(det_any)))
		else $error("Combined error event not pulsed.");

	done_event_a: assert property (UNIT_ON && frame_done |=> evt_tx_done_o && evt_idle_o == $past(tx_empty))
		else $error("Transfer end or idle event wrong.");

	ctrl_write_a: assert property (wr_ctrl && w_low |=> autostop == $past(w_data[`C2_AUTOSTOP]))
		else $error("Auto-stop enable not written.");

	autostop_halt_a: assert property (at_last && rx_full && master && autostop |=> clock_halt_o && (!ovr_err || $past(ovr_err)))
		else $error("Auto-stop did not halt the clock.");

	mode_fault_flag_shared_a: assert property ($rose(udr_err) |-> status_word[`ST_MODE_FAULT_FLAG] && status_word[`ST_UDR])
		else $error("Underrun not shown on mode-fault flag.");

	underrun_set_a: assert property (det_udr |=> udr_err)
		else $error("Underrun flag not set.");

	module_stop_a: assert property (mstop |-> clock_halt_o ##1 link_state == spi_evt_pkg::LINK_IDLE)
		else $error("Module stop did not halt the unit.");

	sticky_flag_a: assert property (par_err && !wr_stat |=> par_err)
		else $error("Parity flag dropped without a write.");

endmodule

//--- verif/spi_link_peer.sv
/*
 Far-side serial master model: link clock frames and a fault select pin.
 Assumes halt_i is the local clock halt, which a master obeys.
*/
`timescale 1ns/1ps

module spi_link_peer (
	input  wire logic halt_i,
	output logic      sclk_o,
	output logic      fsel_n_o
);
	// Clock rests low between frames; the select line has a pull-up.
	initial
	begin
		sclk_o = 1'h0;
		fsel_n_o = 1'h1;
	end

	// Eight clock edges at 160 ns; a real master pauses while halted.
	task automatic send_frame(input bit obey);
		repeat (8)
		begin
			if (obey)
				wait (!halt_i);
			#80 sclk_o = 1'h1;
			#80 sclk_o = 1'h0;
		end
	endtask

	// Another master briefly takes the bus.
	task automatic pulse_fault();
		#100 fsel_n_o = 1'h0;
		#200 fsel_n_o = 1'h1;
	endtask
endmodule

//--- verif/spi_status_event_tb.sv
/*
 Bench for the serial status, event and auto-stop block.
 Assumes the design sources and the link peer model are compiled first.
*/
`timescale 1ns/1ps

module spi_status_event_tb;
	logic        clk_sys_i = 1'h0;
	logic        rst_i = 1'h1;
	logic [7:0]  awaddr = 8'h0;
	logic [7:0]  araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'h0;
	logic        wvalid = 1'h0;
	logic        bready = 1'h0;
	logic        arvalid = 1'h0;
	logic        rready = 1'h0;
	logic [2:0]  strobe = 3'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        sclk, fsel_n, halt, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	wire  [4:0]  ev;
	int          cnt [5] = '{default: 0};
	int          err_count = 0;
	int          checks_done = 0;
	logic [31:0] got;
	logic [1:0]  resp;

	always #10 clk_sys_i = ~clk_sys_i;

	spi_status_event dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
		.wdata_i(wdata), .wstrb_i(4'hF), .wvalid_i(wvalid), .wready_o(wready),
		.bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
		.araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
		.rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
		.serial_transfer_clock_i(sclk), .fault_select_n_i(fsel_n),
		.rx_buffer_read_i(strobe[0]), .tx_buffer_write_i(strobe[1]),
		.parity_error_i(strobe[2]), .clock_halt_o(halt),
		.evt_rx_full_o(ev[0]), .evt_tx_empty_o(ev[1]), .evt_error_o(ev[2]),
		.evt_idle_o(ev[3]), .evt_tx_done_o(ev[4]), .irq_o(irq));

	spi_link_peer peer_u (.halt_i(halt), .sclk_o(sclk), .fsel_n_o(fsel_n));

	// Count event pulses; each lasts one cycle, so one count per pulse.
	always @(posedge clk_sys_i)
		for (int i = 0; i < 5; i++)
			if (ev[i] === 1'h1)
				cnt[i] <= cnt[i] + 1;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
		checks_done++;
		if (act !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, act);
		end
	endtask

	// Ready is looked at mid-cycle, where it equals its value at the next edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit a_ok;
		bit w_ok;
		bit b_ok;
		bit a_done;
		bit w_done;
		b_ok = 0;
		a_done = 0;
		w_done = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!b_ok)
		begin
			@(negedge clk_sys_i);
			a_ok = awvalid && awready;
			w_ok = wvalid && wready;
			b_ok = bvalid;
			r = bresp;
			@(posedge clk_sys_i);
			if (a_ok) awvalid <= 1'h0;
			if (w_ok) wvalid <= 1'h0;
			a_done = a_done | a_ok;
			w_done = w_done | w_ok;
		end
		bready <= 1'h0;
		// Let an edge pass so a following call never drives bready twice at once.
		@(posedge clk_sys_i);
		chk("write answer", 32'h1, {31'h0, a_done & w_done});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit a_ok;
		bit v_ok;
		bit a_done;
		v_ok = 0;
		a_done = 0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!v_ok)
		begin
			@(negedge clk_sys_i);
			a_ok = arvalid && arready;
			v_ok = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys_i);
			if (a_ok) arvalid <= 1'h0;
			a_done = a_done | a_ok;
		end
		rready <= 1'h0;
		@(posedge clk_sys_i);
		chk("read answer", 32'h1, {31'h0, a_done});
	endtask

	task automatic reg_is(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(what, exp, d);
		chk("read resp", 32'h0, {30'h0, r});
	endtask

	task automatic set(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("write resp", 32'h0, {30'h0, r});
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	task automatic pulse(input int i);
		strobe[i] <= 1'h1;
		@(posedge clk_sys_i);
		strobe <= 3'h0;
	endtask

	// The pin sampler needs a few cycles after the last link edge.
	task automatic frame(input bit obey);
		peer_u.send_frame(obey);
		idle(12);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// The whole run needs some 11 us.
	initial
	begin
		#200000;
		err_count++;
		close_out();
	end

	// ------------------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'h0;
		@(posedge clk_sys_i);
		reg_is("status", 8'h00, 32'h1);
		reg_is("ctrl2", 8'h04, 32'h4);
		chk("halt", 32'h1, {31'h0, halt});
		rd(8'h20, got, resp);
		chk("unmapped read", 32'h2, {30'h0, resp});
		wr(8'h24, 32'h0, resp);
		chk("unmapped write", 32'h2, {30'h0, resp});
		$display("test reset done");
		// A slave frame with nothing loaded underruns.
		set(8'h10, 32'h1F);
		set(8'h04, 32'h0);
		frame(1);
		reg_is("status", 8'h00, 32'hF);
		chk("error events", 32'h1, cnt[2]);
		chk("idle events", 32'h1, cnt[3]);
		chk("done events", 32'h1, cnt[4]);
		chk("rx events", 32'h1, cnt[0]);
		chk("irq", 32'h1, {31'h0, irq});
		reg_is("status", 8'h00, 32'hF);
		set(8'h00, 32'h3);
		reg_is("status", 8'h00, 32'h3);
		reg_is("irq status", 8'h08, 32'h1D);
		set(8'h0C, 32'h1F);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test underrun done");
		// Receive buffer still full at the next frame: overrun.
		pulse(1);
		reg_is("status", 8'h00, 32'h2);
		frame(1);
		reg_is("status", 8'h00, 32'h13);
		chk("tx events", 32'h1, cnt[1]);
		chk("error events", 32'h2, cnt[2]);
		set(8'h00, 32'h3);
		$display("test overrun done");
		// Master receive with auto-stop halts instead of overrunning.
		pulse(0);
		set(8'h04, 32'h3);
		pulse(1);
		frame(1);
		frame(1);
		chk("halted", 32'h1, {31'h0, halt});
		reg_is("status", 8'h00, 32'h3);
		pulse(0);
		idle(2);
		chk("released", 32'h0, {31'h0, halt});
		chk("error events", 32'h2, cnt[2]);
		chk("done events", 32'h4, cnt[4]);
		$display("test auto-stop done");
		// Mode fault, then parity with the interrupt masked.
		set(8'h0C, 32'h1F);
		set(8'h10, 32'h0);
		peer_u.pulse_fault();
		idle(8);
		pulse(2);
		idle(2);
		reg_is("status", 8'h00, 32'h27);
		chk("error events", 32'h4, cnt[2]);
		chk("masked", 32'h0, {31'h0, irq});
		set(8'h10, 32'h4);
		chk("unmasked", 32'h1, {31'h0, irq});
		reg_is("irq enable", 8'h10, 32'h4);
		set(8'h00, 32'h23);
		reg_is("status", 8'h00, 32'h23);
		$display("test faults done");
		// Module stop ignores link traffic.
		set(8'h04, 32'h4);
		chk("stopped", 32'h1, {31'h0, halt});
		frame(0);
		chk("done events", 32'h4, cnt[4]);
		reg_is("status", 8'h00, 32'h23);
		$display("test module stop done");
		close_out();
	end
endmodule
